/* hw/core_bus_matrix_address_router.sv */
// Purpose: Arbitrate core and debug accesses and route them by address.
// Assumes: Requesters are logic on CLK and hold a request until its done.
// Notes:   One access is in flight at a time; cost counts from acceptance.
// Contract
// - Accept core and debug requests, arbitrate onto bus, I/O and system space.
// - On contention the core is always granted before the debug port.
// - Debug traffic can delay a core access that arrives while a debug access is in flight.
// - One address map serves core and debug requests alike.
// - Addresses below 0xD0000000 or above 0xEFFFFFFF go to the AHB port.
// - Addresses 0xD0000000 to 0xDFFFFFFF go to the single-cycle I/O block.
// - Addresses 0xE0000000 to 0xEFFFFFFF stay internal, never on AHB.
// - Only word transfers are allowed from 0xD0000000 to 0xEFFFFFFF.
// - Fetch outside executable regions is execute-never and raises a fault.
// - Protection may alter every region except the fixed 0xE0000000 range.
// - Single access costs 2 cycles to AHB or system space, 1 to the I/O block.
// - List load, store, push and pop without LR or PC cost 1+N cycles.
// - Push with LR costs 1+N; pop with PC costs 3+N, N counting them.
`timescale 1ns/1ns
`include "core_bus_matrix_map.svh"

module core_bus_matrix_address_router (
    input  wire logic                         CLK,
    input  wire logic                         RSTN,
    input  wire logic                         CORE_REQ_VALID,
    input  wire core_bus_matrix_pkg::req_type CORE_REQ,
    input  wire logic                         DBG_REQ_VALID,
    input  wire core_bus_matrix_pkg::req_type DBG_REQ,
    input  wire logic                         PROT_DENY,
    input  wire logic                         EXT_READY,
    input  wire logic [31:0]                  EXT_RDATA,
    input  wire logic [31:0]                  IO_RDATA,
    input  wire logic [31:0]                  SYS_RDATA,
    output core_bus_matrix_pkg::tgt_type      TGT,
    output logic                              EXT_VALID,
    output logic                              IO_VALID,
    output logic                              SYS_VALID,
    output logic                              CORE_DONE,
    output logic                              DBG_DONE,
    output logic                              ACCESS_ERR,
    output logic                              SEVERE_FAULT,
    output logic [31:0]                       RDATA
);

    // ------------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------------
    function automatic core_bus_matrix_pkg::route_type route_of(input logic [31:0] a);
        if (a < `MAP_IO_BASE || a > `MAP_SYS_LAST) begin
            return core_bus_matrix_pkg::ROUTE_EXT;
        end else if (a < `MAP_SYS_BASE) begin
            return core_bus_matrix_pkg::ROUTE_IO;
        end
        return core_bus_matrix_pkg::ROUTE_SYS;
    endfunction

    function automatic logic word_only(input logic [31:0] a);
        return (a >= `MAP_IO_BASE) && (a <= `MAP_SYS_LAST);
    endfunction

    function automatic logic exec_ok(input logic [31:0] a);
        return (a <= `MAP_EXEC0_LAST) || (a >= `MAP_EXEC1_BASE && a <= `MAP_EXEC1_LAST);
    endfunction

    // ------------------------------------------------------------------
    // Arbitration and request checks
    // ------------------------------------------------------------------
    core_bus_matrix_pkg::state_type state;
    core_bus_matrix_pkg::route_type route;
    core_bus_matrix_pkg::route_type sel_route;
    core_bus_matrix_pkg::req_type   sel;
    logic                           owner_dbg;
    logic [4:0]                     cnt;
    logic                           err_lat;
    logic                           nx_lat;
    logic                           idle;
    logic                           take_core;
    logic                           take_dbg;
    logic                           take;
    logic                           size_err;
    logic                           nx_err;
    logic                           deny_err;
    logic                           bad;
    logic [4:0]                     next_cost;
    logic                           advance;

    assign idle      = (state == core_bus_matrix_pkg::ST_IDLE);
    // The core wins every idle cycle; debug only fills cycles the core leaves free.
    assign take_core = idle && CORE_REQ_VALID;
    assign take_dbg  = idle && !CORE_REQ_VALID && DBG_REQ_VALID;
    assign take      = take_core || take_dbg;
    assign sel       = take_core ? CORE_REQ : DBG_REQ;
    // Both requesters go through the same decoder.
    assign sel_route = route_of(sel.addr);
    assign size_err  = word_only(sel.addr) && (sel.size != `SIZE_WORD);
    // The protection input cannot reach the fixed interrupt and debug range.
    assign deny_err  = PROT_DENY && (sel_route != core_bus_matrix_pkg::ROUTE_SYS);
    assign nx_err    = sel.fetch && !exec_ok(sel.addr);
    assign bad       = size_err || deny_err || nx_err;
    assign advance   = (route != core_bus_matrix_pkg::ROUTE_EXT) || EXT_READY;

    always_comb begin
        next_cost = `COST_BUS;
        if (bad) begin
            next_cost = `COST_ERR;
        end else begin
            case (sel.kind)
                core_bus_matrix_pkg::KIND_SINGLE: begin
                    if (sel_route == core_bus_matrix_pkg::ROUTE_IO) begin
                        next_cost = `COST_IO;
                    end else begin
                        next_cost = `COST_BUS;
                    end
                end
                core_bus_matrix_pkg::KIND_LIST: begin
                    next_cost = `COST_LIST_BASE + {1'b0, sel.count};
                end
                core_bus_matrix_pkg::KIND_PUSH_LR: begin
                    next_cost = `COST_LIST_BASE + {1'b0, sel.count};
                end
                core_bus_matrix_pkg::KIND_POP_PC: begin
                    next_cost = `COST_POP_PC + {1'b0, sel.count};
                end
                default: begin
                    next_cost = `COST_BUS;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= core_bus_matrix_pkg::ST_IDLE;
        end else begin
            case (state)
                core_bus_matrix_pkg::ST_IDLE: begin
                    if (take) begin
                        state <= core_bus_matrix_pkg::ST_BUSY;
                    end
                end
                core_bus_matrix_pkg::ST_BUSY: begin
                    if (advance && cnt == `COUNT_ONE) begin
                        state <= core_bus_matrix_pkg::ST_DONE;
                    end
                end
                // The done cycle lets the requester drop or replace its request.
                core_bus_matrix_pkg::ST_DONE: begin
                    state <= core_bus_matrix_pkg::ST_IDLE;
                end
                default: begin
                    state <= core_bus_matrix_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cnt <= `COUNT_ONE;
        end else if (take) begin
            cnt <= next_cost;
        end else if (state == core_bus_matrix_pkg::ST_BUSY && advance) begin
            cnt <= cnt - `COUNT_ONE;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            owner_dbg <= 1'b0;
            route     <= core_bus_matrix_pkg::ROUTE_NONE;
            err_lat   <= 1'b0;
            nx_lat    <= 1'b0;
        end else if (take) begin
            owner_dbg <= take_dbg;
            route     <= bad ? core_bus_matrix_pkg::ROUTE_NONE : sel_route;
            err_lat   <= bad;
            nx_lat    <= nx_err;
        end
    end

    // ------------------------------------------------------------------
    // Target strobes
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            EXT_VALID <= 1'b0;
            IO_VALID  <= 1'b0;
            SYS_VALID <= 1'b0;
            TGT       <= '0;
        end else begin
            EXT_VALID <= take && !bad && sel_route == core_bus_matrix_pkg::ROUTE_EXT;
            IO_VALID  <= take && !bad && sel_route == core_bus_matrix_pkg::ROUTE_IO;
            SYS_VALID <= take && !bad && sel_route == core_bus_matrix_pkg::ROUTE_SYS;
            if (take) begin
                TGT <= '{addr: sel.addr, wdata: sel.wdata, write: sel.write, size: sel.size};
            end
        end
    end

    // ------------------------------------------------------------------
    // Completion
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            CORE_DONE    <= 1'b0;
            DBG_DONE     <= 1'b0;
            ACCESS_ERR   <= 1'b0;
            SEVERE_FAULT <= 1'b0;
            RDATA        <= '0;
        end else begin
            CORE_DONE    <= 1'b0;
            DBG_DONE     <= 1'b0;
            ACCESS_ERR   <= 1'b0;
            SEVERE_FAULT <= 1'b0;
            if (state == core_bus_matrix_pkg::ST_BUSY && advance && cnt == `COUNT_ONE) begin
                CORE_DONE    <= !owner_dbg;
                DBG_DONE     <= owner_dbg;
                ACCESS_ERR   <= err_lat;
                SEVERE_FAULT <= nx_lat;
                case (route)
                    core_bus_matrix_pkg::ROUTE_EXT: RDATA <= EXT_RDATA;
                    core_bus_matrix_pkg::ROUTE_IO:  RDATA <= IO_RDATA;
                    core_bus_matrix_pkg::ROUTE_SYS: RDATA <= SYS_RDATA;
                    default:                        RDATA <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Latency helper: counts cycles from acceptance to the done pulse.
    logic [4:0] lat;
    logic [4:0] cost_chk;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            lat      <= '0;
            cost_chk <= '0;
        end else if (take) begin
            lat      <= `COUNT_ONE;
            cost_chk <= next_cost;
        end else if (state == core_bus_matrix_pkg::ST_BUSY) begin
            lat      <= lat + `COUNT_ONE;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    sequence s_busy_then_done;
        state == core_bus_matrix_pkg::ST_BUSY ##1 (CORE_DONE || DBG_DONE);
    endsequence

    sequence s_fault_done;
        !EXT_VALID && !IO_VALID && !SYS_VALID ##1 (ACCESS_ERR && SEVERE_FAULT);
    endsequence

    a_core_first_grant: assert property (
        idle && CORE_REQ_VALID && DBG_REQ_VALID |=> !owner_dbg && !DBG_DONE[*2])
        else $error("debug granted over a pending core request");

    a_core_not_delayed: assert property (
        idle && CORE_REQ_VALID |=> state == core_bus_matrix_pkg::ST_BUSY && !owner_dbg)
        else $error("core request not taken at once when idle");

    a_dbg_stalls_core: assert property (
        state == core_bus_matrix_pkg::ST_IDLE && $past(CORE_REQ_VALID) && DBG_REQ_VALID
        && CORE_REQ_VALID |=> !owner_dbg)
        else $error("debug request passed a busy core");

    a_ext_range_only: assert property (
        EXT_VALID |-> (TGT.addr < `MAP_IO_BASE || TGT.addr > `MAP_SYS_LAST))
        else $error("external strobe for an internal address");

    a_io_range_only: assert property (
        IO_VALID |-> TGT.addr >= `MAP_IO_BASE && TGT.addr < `MAP_SYS_BASE)
        else $error("I/O strobe outside its window");

    a_sys_stays_inside: assert property (
        take && !bad && sel_route == core_bus_matrix_pkg::ROUTE_SYS
        |=> SYS_VALID && !EXT_VALID)
        else $error("internal range access missing or leaked outside");

    a_word_only_range: assert property (
        (EXT_VALID || IO_VALID || SYS_VALID) && word_only(TGT.addr)
        |-> TGT.size == `SIZE_WORD)
        else $error("narrow transfer forwarded into word-only range");

    a_narrow_errors: assert property (
        take && size_err |=> s_fault_done or
        (!EXT_VALID && !IO_VALID && !SYS_VALID ##1 ACCESS_ERR))
        else $error("narrow access not refused with an error");

    a_fetch_nx_fault: assert property (
        take && nx_err |=> s_fault_done)
        else $error("fetch from execute-never region without fault");

    a_sys_prot_fixed: assert property (
        take && PROT_DENY && !sel.fetch && sel.size == `SIZE_WORD
        && sel_route == core_bus_matrix_pkg::ROUTE_SYS |=> SYS_VALID)
        else $error("protection blocked the fixed internal range");

    a_io_single_cost: assert property (
        take && !bad && sel.kind == core_bus_matrix_pkg::KIND_SINGLE
        && sel_route == core_bus_matrix_pkg::ROUTE_IO |=> s_busy_then_done)
        else $error("single I/O access not one cycle");

    a_list_cost: assert property (
        (CORE_DONE || DBG_DONE) && $past(route) != core_bus_matrix_pkg::ROUTE_EXT
        |-> $past(lat) == $past(cost_chk))
        else $error("access latency differs from its cycle cost");

    a_one_in_flight: assert property (
        take |=> !take[*2])
        else $error("second access accepted while one is in flight");

endmodule

/* hw/core_bus_matrix_map.svh */
// Purpose: Address map, transfer sizes and cycle costs of the bus matrix.
// Assumes: Included by its bare name by the matrix design file.
// Notes:   Definitions only.
`ifndef CORE_BUS_MATRIX_MAP_SVH
`define CORE_BUS_MATRIX_MAP_SVH

// ----------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------
`define MAP_IO_BASE     32'hD000_0000
`define MAP_SYS_BASE    32'hE000_0000
`define MAP_SYS_LAST    32'hEFFF_FFFF
`define MAP_EXEC0_LAST  32'h3FFF_FFFF
`define MAP_EXEC1_BASE  32'h6000_0000
`define MAP_EXEC1_LAST  32'h9FFF_FFFF

// ----------------------------------------------------------------------
// Transfer size and cycle costs
// ----------------------------------------------------------------------
`define SIZE_WORD       2'h2
`define COST_BUS        5'h02
`define COST_IO         5'h01
`define COST_ERR        5'h01
`define COST_LIST_BASE  5'h01
`define COST_POP_PC     5'h03
`define COUNT_ONE       5'h01

`endif

/* hw/core_bus_matrix_pkg.sv */
// Purpose: Types shared by the bus matrix and its bench.
// Assumes: Constants live in core_bus_matrix_map.svh.
// Notes:   Widths of the request carrier are fixed at 32-bit addressing.
package core_bus_matrix_pkg;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ROUTE_EXT  = 2'b00,
        ROUTE_IO   = 2'b01,
        ROUTE_SYS  = 2'b10,
        ROUTE_NONE = 2'b11
    } route_type;

    typedef enum logic [1:0] {
        KIND_SINGLE  = 2'b00,
        KIND_LIST    = 2'b01,
        KIND_PUSH_LR = 2'b10,
        KIND_POP_PC  = 2'b11
    } kind_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_DONE = 2'b10
    } state_type;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        write;
        logic [1:0]  size;
        logic        fetch;
        kind_type    kind;
        logic [3:0]  count;
    } req_type;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        write;
        logic [1:0]  size;
    } tgt_type;

endpackage

/* test/core_bus_target_model.sv */
// Purpose: Far-side model of the external port, I/O block and control space.
// Assumes: Fed by the matrix external strobe and the routed address on CLK.
// Notes:   Wait states stretch the external port only.
`timescale 1ns/1ns

module core_bus_target_model (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic        EXT_VALID,
    input  wire logic [31:0] ADDR,
    input  wire logic [3:0]  WAIT_CYCLES,
    output logic             EXT_READY,
    output logic [31:0]      EXT_RDATA,
    output logic [31:0]      IO_RDATA,
    output logic [31:0]      SYS_RDATA
);
    logic [3:0] wait_left;

    // ------------------------------------------------------------------
    // Slow replies
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            wait_left <= 4'h0;
        end else if (EXT_VALID) begin
            wait_left <= WAIT_CYCLES;
        end else if (wait_left != 4'h0) begin
            wait_left <= wait_left - 4'h1;
        end
    end

    assign EXT_READY = (wait_left == 4'h0);

    // Each target answers a different function of the address, so a misrouted
    // read shows up in the data and not only in the strobes.
    assign EXT_RDATA = ~ADDR;
    assign IO_RDATA  = ADDR ^ 32'h5A5A_5A5A;
    assign SYS_RDATA = ADDR + 32'h0000_0001;
endmodule

/* test/test_core_bus_matrix_address_router.sv */
// Purpose: Self-checking bench of the bus matrix routing, faults and costs.
// Assumes: Requests are held until their done pulse, one access at a time.
// Notes:   Costs are counted in edges from the taking edge to the done pulse.
`timescale 1ns/1ns

module test_core_bus_matrix_address_router;
    logic                         CLK = 1'b0;
    logic                         RSTN;
    logic                         CORE_REQ_VALID;
    core_bus_matrix_pkg::req_type CORE_REQ;
    logic                         DBG_REQ_VALID;
    core_bus_matrix_pkg::req_type DBG_REQ;
    logic                         PROT_DENY;
    logic                         EXT_READY;
    logic [31:0]                  EXT_RDATA;
    logic [31:0]                  IO_RDATA;
    logic [31:0]                  SYS_RDATA;
    core_bus_matrix_pkg::tgt_type TGT;
    logic                         EXT_VALID;
    logic                         IO_VALID;
    logic                         SYS_VALID;
    logic                         CORE_DONE;
    logic                         DBG_DONE;
    logic                         ACCESS_ERR;
    logic                         SEVERE_FAULT;
    logic [31:0]                  RDATA;
    logic [3:0]                   WAIT_CYCLES;
    int                           n_errors = 0;
    int                           checks = 0;
    int                           cycles = 0;

    core_bus_matrix_address_router u_core_bus_matrix_address_router (
        .CLK(CLK), .RSTN(RSTN), .CORE_REQ_VALID(CORE_REQ_VALID), .CORE_REQ(CORE_REQ),
        .DBG_REQ_VALID(DBG_REQ_VALID), .DBG_REQ(DBG_REQ), .PROT_DENY(PROT_DENY),
        .EXT_READY(EXT_READY), .EXT_RDATA(EXT_RDATA), .IO_RDATA(IO_RDATA),
        .SYS_RDATA(SYS_RDATA), .TGT(TGT), .EXT_VALID(EXT_VALID), .IO_VALID(IO_VALID),
        .SYS_VALID(SYS_VALID), .CORE_DONE(CORE_DONE), .DBG_DONE(DBG_DONE),
        .ACCESS_ERR(ACCESS_ERR), .SEVERE_FAULT(SEVERE_FAULT), .RDATA(RDATA));

    core_bus_target_model u_core_bus_target_model (
        .CLK(CLK), .RSTN(RSTN), .EXT_VALID(EXT_VALID), .ADDR(TGT.addr),
        .WAIT_CYCLES(WAIT_CYCLES), .EXT_READY(EXT_READY), .EXT_RDATA(EXT_RDATA),
        .IO_RDATA(IO_RDATA), .SYS_RDATA(SYS_RDATA));

    // ------------------------------------------------------------------
    // Clock, timeout and reporting
    // ------------------------------------------------------------------
    always #5 CLK = ~CLK;

    always @(posedge CLK) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        $display("Checks %0d, errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic core_bus_matrix_pkg::req_type mk(input logic [31:0] a,
            input logic w, input logic [1:0] sz, input logic f,
            input core_bus_matrix_pkg::kind_type kd, input logic [3:0] n);
        core_bus_matrix_pkg::req_type r;
        r = '{addr: a, wdata: a ^ 32'hFFFF_0000, write: w, size: sz, fetch: f,
              kind: kd, count: n};
        return r;
    endfunction

    function automatic logic [31:0] exp_data(input logic [2:0] stb, input logic [31:0] a);
        return stb == 3'b100 ? ~a : stb == 3'b010 ? a ^ 32'h5A5A_5A5A :
               stb == 3'b001 ? a + 32'h0000_0001 : 32'h0000_0000;
    endfunction

    // Strobe expected in the first busy cycle, as {external, I/O, control space}.
    function automatic logic [2:0] route_of(input logic [31:0] a);
        return a[31:28] == 4'hD ? 3'b010 : a[31:28] == 4'hE ? 3'b001 : 3'b100;
    endfunction

    task automatic access(input logic dbg, input core_bus_matrix_pkg::req_type r,
            input logic deny, input int cost, input logic err, input logic fault);
        logic [2:0] stb;
        logic [2:0] exp_stb;
        int         k;
        int         nstb;
        exp_stb = err ? 3'b000 : route_of(r.addr);
        k = 0;
        nstb = 0;
        stb = 3'b000;
        PROT_DENY <= deny;
        if (dbg) begin
            DBG_REQ_VALID <= 1'b1;
            DBG_REQ <= r;
        end else begin
            CORE_REQ_VALID <= 1'b1;
            CORE_REQ <= r;
        end
        do begin
            @(posedge CLK);
            k++;
            nstb += int'(EXT_VALID) + int'(IO_VALID) + int'(SYS_VALID);
            if (k == 2) stb = {EXT_VALID, IO_VALID, SYS_VALID};
        end while ((dbg ? DBG_DONE : CORE_DONE) !== 1'b1 && k < 40);
        chk("cost", 32'(k - 2), 32'(cost));
        chk("strobe", {29'h0, stb}, {29'h0, exp_stb});
        chk("strobes", 32'(nstb), {31'h0, !err});
        chk("err", {31'h0, ACCESS_ERR}, {31'h0, err});
        chk("fault", {31'h0, SEVERE_FAULT}, {31'h0, fault});
        chk("other done", {31'h0, dbg ? CORE_DONE : DBG_DONE}, 32'h0000_0000);
        if (!err) chk("tgt", TGT.addr, r.addr);
        if (!err) chk("tgt wdata", TGT.wdata, r.wdata);
        if (!err) chk("tgt ctl", {29'h0, TGT.write, TGT.size},
                      {29'h0, r.write, r.size});
        if (!r.write || err) chk("rdata", RDATA, exp_data(exp_stb, r.addr));
        CORE_REQ_VALID <= 1'b0;
        DBG_REQ_VALID <= 1'b0;
        PROT_DENY <= 1'b0;
        @(posedge CLK);
        chk("pulse", {31'h0, dbg ? DBG_DONE : CORE_DONE}, 32'h0000_0000);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_route;
        logic [31:0] a [8] = '{32'h0000_0000, 32'hCFFF_FFFC, 32'hD000_0000, 32'hDFFF_FFFC,
                               32'hE000_0000, 32'hEFFF_FFFC, 32'hF000_0000, 32'hFFFF_FFFC};
        for (int i = 0; i < 8; i++) begin
            for (int w = 0; w < 2; w++) begin
                access(1'b0, mk(a[i], w[0], 2'h2, 1'b0, core_bus_matrix_pkg::KIND_SINGLE,
                       4'h0), 1'b0, a[i][31:28] == 4'hD ? 1 : 2, 1'b0, 1'b0);
            end
            access(1'b1, mk(a[i], 1'b0, 2'h2, 1'b0, core_bus_matrix_pkg::KIND_SINGLE, 4'h0),
                   1'b0, a[i][31:28] == 4'hD ? 1 : 2, 1'b0, 1'b0);
        end
    endtask

    task automatic t_narrow;
        access(1'b0, mk(32'hD000_0004, 1'b0, 2'h0, 1'b0, core_bus_matrix_pkg::KIND_SINGLE,
               4'h0), 1'b0, 1, 1'b1, 1'b0);
        access(1'b1, mk(32'hE000_0010, 1'b1, 2'h1, 1'b0, core_bus_matrix_pkg::KIND_SINGLE,
               4'h0), 1'b0, 1, 1'b1, 1'b0);
        access(1'b0, mk(32'h2000_0001, 1'b0, 2'h0, 1'b0, core_bus_matrix_pkg::KIND_SINGLE,
               4'h0), 1'b0, 2, 1'b0, 1'b0);
    endtask

    task automatic t_fetch;
        logic [31:0] a [8] = '{32'h0000_0000, 32'h3FFF_FFFC, 32'h4000_0000, 32'h6000_0000,
                               32'h9FFF_FFFC, 32'hA000_0000, 32'hE000_0000, 32'hF000_0000};
        logic [7:0]  nx = 8'b1110_0100;
        for (int i = 0; i < 8; i++) begin
            access(1'b0, mk(a[i], 1'b0, 2'h2, 1'b1, core_bus_matrix_pkg::KIND_SINGLE, 4'h0),
                   1'b0, nx[i] ? 1 : 2, nx[i], nx[i]);
        end
    endtask

    task automatic t_protect;
        access(1'b0, mk(32'h2000_0000, 1'b1, 2'h2, 1'b0, core_bus_matrix_pkg::KIND_SINGLE,
               4'h0), 1'b1, 1, 1'b1, 1'b0);
        access(1'b0, mk(32'hE000_E100, 1'b0, 2'h2, 1'b0, core_bus_matrix_pkg::KIND_SINGLE,
               4'h0), 1'b1, 2, 1'b0, 1'b0);
    endtask

    task automatic t_lists;
        access(1'b0, mk(32'h2000_0100, 1'b0, 2'h2, 1'b0, core_bus_matrix_pkg::KIND_LIST,
               4'h1), 1'b0, 2, 1'b0, 1'b0);
        access(1'b0, mk(32'hD000_0100, 1'b1, 2'h2, 1'b0, core_bus_matrix_pkg::KIND_LIST,
               4'h8), 1'b0, 9, 1'b0, 1'b0);
        access(1'b0, mk(32'h2000_0200, 1'b1, 2'h2, 1'b0, core_bus_matrix_pkg::KIND_PUSH_LR,
               4'h2), 1'b0, 3, 1'b0, 1'b0);
        access(1'b0, mk(32'h2000_0300, 1'b0, 2'h2, 1'b0, core_bus_matrix_pkg::KIND_POP_PC,
               4'h2), 1'b0, 5, 1'b0, 1'b0);
    endtask

    task automatic t_wait;
        WAIT_CYCLES <= 4'h3;
        access(1'b0, mk(32'h1000_0040, 1'b0, 2'h2, 1'b0, core_bus_matrix_pkg::KIND_SINGLE,
               4'h0), 1'b0, 5, 1'b0, 1'b0);
        WAIT_CYCLES <= 4'h0;
    endtask

    // Both requesters raise at once; the core then chains a second access.
    task automatic t_arb;
        int k = 0;
        int kc1 = 0;
        int kc2 = 0;
        int kd = 0;
        CORE_REQ_VALID <= 1'b1;
        CORE_REQ <= mk(32'h2000_0000, 1'b0, 2'h2, 1'b0, core_bus_matrix_pkg::KIND_SINGLE, 4'h0);
        DBG_REQ_VALID <= 1'b1;
        DBG_REQ <= mk(32'hE000_ED00, 1'b0, 2'h2, 1'b0, core_bus_matrix_pkg::KIND_SINGLE, 4'h0);
        while (kd == 0 && k < 40) begin
            @(posedge CLK);
            k++;
            if (CORE_DONE === 1'b1 && kc1 == 0) begin
                kc1 = k;
                CORE_REQ <= mk(32'hD000_0008, 1'b0, 2'h2, 1'b0,
                               core_bus_matrix_pkg::KIND_SINGLE, 4'h0);
            end else if (CORE_DONE === 1'b1) begin
                kc2 = k;
                CORE_REQ_VALID <= 1'b0;
            end
            if (DBG_DONE === 1'b1) begin
                kd = k;
                DBG_REQ_VALID <= 1'b0;
                chk("dbg rdata", RDATA, 32'hE000_ED01);
            end
        end
        chk("core first", 32'(kc1), 32'h0000_0004);
        chk("core second", 32'(kc2), 32'h0000_0007);
        chk("dbg done", 32'(kd), 32'h0000_000B);
        @(posedge CLK);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        RSTN = 1'b0;
        CORE_REQ_VALID = 1'b0;
        CORE_REQ = '0;
        DBG_REQ_VALID = 1'b0;
        DBG_REQ = '0;
        PROT_DENY = 1'b0;
        WAIT_CYCLES = 4'h0;
        repeat (10) @(posedge CLK);
        RSTN <= 1'b1;
        @(posedge CLK);
        chk("reset outs", {25'h0, CORE_DONE, DBG_DONE, ACCESS_ERR, SEVERE_FAULT,
            EXT_VALID, IO_VALID, SYS_VALID}, 32'h0000_0000);
        t_route();
        t_narrow();
        t_fetch();
        t_protect();
        t_lists();
        t_wait();
        t_arb();
        tally_and_finish();
    end
endmodule
